// [logic/csx_exec.sv]
module csx_exec
  import csx_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      instrValid,
  input  wire logic [INSTR_W-1:0]        instrWord,
  input  wire logic [DATA_W-1:0]         accIn,
  input  wire logic [DATA_W-1:0]         regRdData,
  input  wire logic                      bankHigh,
  input  wire logic [DATA_W-1:0]         upperLatch,
  output logic                           instrReady,
  output logic                           pcLoad,
  output logic [PC_W-1:0]                pcLoadValue,
  output logic                           discardFetch,
  output logic                           accWrite,
  output logic [DATA_W-1:0]              accWrData,
  output logic                           regWrite,
  output logic [ADDR_W-1:0]              regWrAddr,
  output logic [DATA_W-1:0]              regWrData,
  output logic                           zeroWrite,
  output logic                           zeroValue,
  output logic                           unknownOp,
  output logic [DIR_COUNT*DATA_W-1:0]    dirBits
);
  // ==========================================================
  // state and output flops
  csx_state_t             state_reg;
  csx_state_t             state_next;
  logic                   pcLoad_reg;
  logic [PC_W-1:0]        pcVal_reg;
  logic                   discard_reg;
  logic                   accWr_reg;
  logic [DATA_W-1:0]      accData_reg;
  logic                   regWr_reg;
  logic [ADDR_W-1:0]      regAddr_reg;
  logic [DATA_W-1:0]      regData_reg;
  logic                   zeroWr_reg;
  logic                   zeroVal_reg;
  logic                   unknown_reg;
  logic                   ready_reg;
  logic [DATA_W-1:0]      dir_reg [DIR_COUNT];

  // ==========================================================
  // decode
  wire take        = instrValid && ready_reg;
  wire isJump      = (instrWord & MASK_JUMP) == PAT_JUMP;
  wire isIncSkip   = (instrWord & MASK_OP6) == PAT_INCSKIP;
  wire isInc       = (instrWord & MASK_OP6) == PAT_INC;
  wire isOrLit     = (instrWord & MASK_OP6) == PAT_ORLIT;
  wire isXorLit    = (instrWord & MASK_OP6) == PAT_XORLIT;
  wire isXorReg    = (instrWord & MASK_OP6) == PAT_XORREG;
  wire isSwap      = (instrWord & MASK_OP6) == PAT_SWAP;
  wire isDirLd     = (instrWord & MASK_DIRLD) == PAT_DIRLD;
  wire destReg     = instrWord[DEST_BIT];
  wire [ADDR_W-1:0] fileAddr = instrWord[ADDR_W-1:0];
  wire [DATA_W-1:0] litByte  = instrWord[DATA_W-1:0];
  wire [2:0]        selLow   = instrWord[2:0];
  // selectors below 5 name no direction register and are not executed
  wire dirLdOk     = isDirLd && (selLow >= DIR_SEL_MIN);
  wire fileOp      = isIncSkip || isInc || isXorReg || isSwap;
  wire litOp       = isOrLit || isXorLit;
  wire known       = isJump || fileOp || litOp || dirLdOk;

  // direction registers sit in the upper bank at file addresses 5..7
  wire dirHit      = bankHigh && (fileAddr[ADDR_W-1:3] == 4'h0)
                     && (fileAddr[2:0] >= DIR_SEL_MIN);
  wire [2:0] dirOff3 = selLow - DIR_SEL_MIN;
  wire [1:0] dirIdx  = dirOff3[1:0];
  // index 3 never reaches the operand: dirHit excludes it
  wire [DATA_W-1:0] dirRd = dir_reg[dirIdx];
  wire [DATA_W-1:0] operand = dirHit ? dirRd : regRdData;

  // ==========================================================
  // result selection
  wire [DATA_W-1:0] incSum  = operand + ONE_BYTE;
  wire [DATA_W-1:0] swapped = {operand[3:0], operand[7:4]};
  wire [DATA_W-1:0] xorReg  = accIn ^ operand;
  wire [DATA_W-1:0] orLit   = accIn | litByte;
  wire [DATA_W-1:0] xorLit  = accIn ^ litByte;
  wire [DATA_W-1:0] result  = (isIncSkip || isInc) ? incSum :
                              isSwap               ? swapped :
                              isXorReg             ? xorReg :
                              isOrLit              ? orLit : xorLit;
  wire resultNull  = (result == ZERO_BYTE);
  wire skipNow     = take && isIncSkip && (incSum == ZERO_BYTE);
  wire jumpNow     = take && isJump;
  wire [PC_W-1:0] jumpTarget = {upperLatch[LATCH_HI:LATCH_LO],
                                instrWord[JUMP_LIT_W-1:0]};

  // file ops write the accumulator on dest 0, and on dest 1 the file, or the direction register on a dirHit
  wire accWrNext   = take && ((fileOp && !destReg) || litOp);
  wire fileWrBack  = take && fileOp && destReg;
  wire regWrNext   = fileWrBack && !dirHit;
  wire dirWrEn     = (take && dirLdOk) || (fileWrBack && dirHit);
  wire [1:0] dirWrIdx = dirIdx;
  wire [DATA_W-1:0] dirWrData = isDirLd ? accIn : result;
  // only the increment and the three exclusive/inclusive ops touch the flag
  wire zeroWrNext  = take && (isInc || isXorReg || litOp);

  // ==========================================================
  // sequencing: jumps and taken skips hold one bubble cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CSX_RUN: begin
        if (jumpNow || skipNow) begin
          state_next = CSX_BUBBLE;
        end
      end
      CSX_BUBBLE: begin
        state_next = CSX_RUN;
      end
      default: begin
        state_next = CSX_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= CSX_RUN;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == CSX_RUN);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pcLoad_reg  <= 1'b0;
      pcVal_reg   <= '0;
      discard_reg <= 1'b0;
      unknown_reg <= 1'b0;
    end else begin
      pcLoad_reg  <= jumpNow;
      discard_reg <= skipNow;
      unknown_reg <= take && !known;
      if (jumpNow) begin
        pcVal_reg <= jumpTarget;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      accWr_reg   <= 1'b0;
      accData_reg <= '0;
      regWr_reg   <= 1'b0;
      regAddr_reg <= '0;
      regData_reg <= '0;
    end else begin
      accWr_reg <= accWrNext;
      regWr_reg <= regWrNext;
      if (accWrNext) begin
        accData_reg <= result;
      end
      if (regWrNext) begin
        regAddr_reg <= fileAddr;
        regData_reg <= result;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      zeroWr_reg  <= 1'b0;
      zeroVal_reg <= 1'b0;
    end else begin
      zeroWr_reg <= zeroWrNext;
      if (zeroWrNext) begin
        zeroVal_reg <= resultNull;
      end
    end
  end

  // ==========================================================
  // direction registers, one flop group per entry
  for (genvar g = 0; g < DIR_COUNT; g++) begin : g_dir
    always_ff @(posedge mclk) begin
      if (srst) begin
        dir_reg[g] <= DIR_RESET;
      end else if (dirWrEn && (dirWrIdx == 2'(g))) begin
        dir_reg[g] <= dirWrData;
      end
    end
    assign dirBits[g*DATA_W +: DATA_W] = dir_reg[g];
  end

  assign instrReady   = ready_reg;
  assign pcLoad       = pcLoad_reg;
  assign pcLoadValue  = pcVal_reg;
  assign discardFetch = discard_reg;
  assign accWrite     = accWr_reg;
  assign accWrData    = accData_reg;
  assign regWrite     = regWr_reg;
  assign regWrAddr    = regAddr_reg;
  assign regWrData    = regData_reg;
  assign zeroWrite    = zeroWr_reg;
  assign zeroValue    = zeroVal_reg;
  assign unknownOp    = unknown_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_jump_target: assert property (
    jumpNow |=> pcLoad && pcLoadValue[10:0] == $past(instrWord[10:0]))
    else $error("jump literal not placed in low counter bits");

  a_jump_upper: assert property (
    jumpNow |=> pcLoadValue[12:11] == $past(upperLatch[4:3]))
    else $error("upper counter bits not taken from latch");

  a_jump_two_cycle: assert property (
    jumpNow |=> !instrReady ##1 instrReady && !zeroWrite)
    else $error("jump did not hold exactly one bubble");

  a_jump_no_flag: assert property (
    jumpNow |=> !zeroWrite && !accWrite && !regWrite)
    else $error("jump touched flags or data");

  a_incskip_sum: assert property (
    take && isIncSkip && destReg && !dirHit |=>
      regWrite && regWrData == $past(regRdData) + 8'h01 && !zeroWrite)
    else $error("increment-skip wrote wrong sum or a flag");

  a_dest_select: assert property (
    take && fileOp && !destReg |=> accWrite && !regWrite)
    else $error("destination zero did not select accumulator");

  a_skip_discard: assert property (
    take && isIncSkip && operand == 8'hff |=> discardFetch)
    else $error("null increment did not discard fetch");

  a_skip_bubble: assert property (
    discardFetch |-> !instrReady ##1 instrReady)
    else $error("skip bubble length wrong");

  a_noskip_single: assert property (
    take && isIncSkip && operand != 8'hff |=> instrReady && !discardFetch)
    else $error("increment-skip stalled without null result");

  a_swap_halves: assert property (
    take && isSwap && !destReg |=>
      accWrData == {$past(operand[3:0]), $past(operand[7:4])} && !zeroWrite)
    else $error("nibble exchange wrong");

  a_dirld_copy: assert property (
    take && dirLdOk |=>
      dirBits[($past(selLow) - 3'h5) * 8 +: 8] == $past(accIn) && !zeroWrite)
    else $error("direction load did not copy accumulator");

  a_dir_file_wr: assert property (
    take && fileOp && destReg && dirHit |=> !regWrite)
    else $error("direction register write leaked to file");

  a_null_flag: assert property (
    zeroWrite |-> zeroValue == ((accWrite ? accWrData : regWrData) == 8'h00)
      || !(accWrite || regWrite))
    else $error("null flag disagrees with result");

  a_known_ops: assert property (
    take && !known |=> unknownOp && !pcLoad && !accWrite && !regWrite)
    else $error("unknown pattern had an effect");

  a_orlit_result: assert property (
    take && isOrLit |=> accWrite && accWrData == ($past(accIn) | $past(litByte)))
    else $error("inclusive literal result wrong");

  a_xorlit_result: assert property (
    take && isXorLit |=> accWrite && accWrData == ($past(accIn) ^ $past(litByte)))
    else $error("exclusive literal result wrong");

  a_xorreg_flag: assert property (
    take && isXorReg |=> zeroWrite && zeroValue == (($past(accIn) ^ $past(operand)) == 8'h00))
    else $error("exclusive register null flag wrong");

  a_inc_flag: assert property (
    take && isInc |=> zeroWrite && zeroValue == ($past(operand) == 8'hff))
    else $error("increment null flag wrong");

  a_single_cycle: assert property (
    take && (isInc || isXorReg || litOp) |=> instrReady)
    else $error("one-cycle operation stalled");

  a_pc_hold: assert property (
    !jumpNow |=> $stable(pcLoadValue))
    else $error("counter load value moved without a jump");

  a_discard_pulse: assert property (
    discardFetch |=> !discardFetch)
    else $error("discard held longer than one cycle");

  a_dir_hold: assert property (
    !(take && dirLdOk) && !fileWrBack |=> $stable(dirBits))
    else $error("direction registers changed without a write");

  c_jump:  cover property (jumpNow ##2 take);
  c_dir_file: cover property (take && fileOp && destReg && dirHit);
  c_skip:  cover property (skipNow ##2 take);
  c_dirld: cover property (take && dirLdOk);
  c_swap:  cover property (take && isSwap && destReg);
endmodule

// [logic/csx_pkg.sv]
package csx_pkg;
  // ==========================================================
  // widths and field positions
  localparam int INSTR_W     = 14;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 13;
  localparam int ADDR_W      = 7;
  localparam int JUMP_LIT_W  = 11;
  localparam int DEST_BIT    = 7;
  localparam int LATCH_HI    = 4;
  localparam int LATCH_LO    = 3;
  localparam int DIR_COUNT   = 3;
  // ==========================================================
  // opcode masks and patterns
  localparam logic [13:0] MASK_JUMP   = 14'h3800;
  localparam logic [13:0] PAT_JUMP    = 14'h2800;
  localparam logic [13:0] MASK_OP6    = 14'h3f00;
  localparam logic [13:0] PAT_INCSKIP = 14'h0f00;
  localparam logic [13:0] PAT_INC     = 14'h0a00;
  localparam logic [13:0] PAT_ORLIT   = 14'h3800;
  localparam logic [13:0] PAT_XORLIT  = 14'h3a00;
  localparam logic [13:0] PAT_XORREG  = 14'h0600;
  localparam logic [13:0] PAT_SWAP    = 14'h0e00;
  localparam logic [13:0] MASK_DIRLD  = 14'h3ff8;
  localparam logic [13:0] PAT_DIRLD   = 14'h0060;
  // ==========================================================
  // direction registers and reset values
  localparam logic [2:0]  DIR_SEL_MIN = 3'h5;
  localparam logic [7:0]  DIR_RESET   = 8'hff;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam logic [7:0]  ONE_BYTE    = 8'h01;
  localparam int          CYC_LONG    = 2;

  typedef enum logic [0:0] {
    CSX_RUN    = 1'b0,
    CSX_BUBBLE = 1'b1
  } csx_state_t;
endpackage

// [tb/csx_partner.sv]
module csx_partner
  import csx_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                srst,
  input  wire logic [INSTR_W-1:0]  instrWord,
  input  wire logic                bankHigh,
  input  wire logic                accWrite,
  input  wire logic [DATA_W-1:0]   accWrData,
  input  wire logic                regWrite,
  input  wire logic [ADDR_W-1:0]   regWrAddr,
  input  wire logic [DATA_W-1:0]   regWrData,
  output logic      [DATA_W-1:0]   regRdData,
  output logic      [DATA_W-1:0]   accIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // register file and accumulator
  logic [DATA_W-1:0] memArr [256];
  logic [DATA_W-1:0] accReg;
  // read is combinational, so a write lands one edge later
  assign regRdData = memArr[{bankHigh, instrWord[6:0]}];
  assign accIn = accReg;
  always @(posedge mclk) begin
    if (srst) begin
      accReg <= ZERO_BYTE;
      for (int i = 0; i < 256; i++) memArr[i] <= 8'(i) ^ 8'hf0;
    end else begin
      if (accWrite) accReg <= accWrData;
      if (regWrite) memArr[{bankHigh, regWrAddr}] <= regWrData;
    end
  end
endmodule

// [tb/core_instruction_subset_exec_tb.sv]
module core_instruction_subset_exec_tb import csx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, srst, instrValid, bankHigh, instrReady, pcLoad, discardFetch;
  logic accWrite, regWrite, zeroWrite, zeroValue, unknownOp;
  logic [13:0] instrWord, w;
  logic [12:0] pcLoadValue, ePcv;
  logic [7:0]  accIn, regRdData, upperLatch, accWrData, regWrData, mAcc, eAccD, eRegD;
  logic [6:0]  regWrAddr, eRegA;
  logic [23:0] dirBits;
  logic [7:0]  mMem [256];
  logic [7:0]  mDir [3];
  logic        eReady, ePc, eDis, eAw, eRw, eZw, eZv, eUnk;
  int          failures, samples_checked, cycles, seedDummy;
  // ==========================================================
  // design, partner, clock
  csx_exec dut_u (.mclk(mclk), .srst(srst), .instrValid(instrValid), .instrWord(instrWord),
    .accIn(accIn), .regRdData(regRdData), .bankHigh(bankHigh), .upperLatch(upperLatch),
    .instrReady(instrReady), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
    .discardFetch(discardFetch), .accWrite(accWrite), .accWrData(accWrData),
    .regWrite(regWrite), .regWrAddr(regWrAddr), .regWrData(regWrData),
    .zeroWrite(zeroWrite), .zeroValue(zeroValue), .unknownOp(unknownOp), .dirBits(dirBits));
  csx_partner part_u (.mclk(mclk), .srst(srst), .instrWord(instrWord), .bankHigh(bankHigh),
    .accWrite(accWrite), .accWrData(accWrData), .regWrite(regWrite), .regWrAddr(regWrAddr),
    .regWrData(regWrData), .regRdData(regRdData), .accIn(accIn));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end
  // ==========================================================
  // checking
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // stimulus and reference model
  function automatic logic [13:0] gen_word();
    logic [13:0] regPats [4];
    int kind;
    regPats = '{PAT_INCSKIP, PAT_INC, PAT_SWAP, PAT_XORREG};
    kind = $urandom % 9;
    case (kind)
      0: return PAT_JUMP | {3'h0, 11'($urandom)};
      1, 2, 3, 4: return regPats[kind-1] | {6'h00, 1'($urandom), 7'($urandom % 16)};
      5: return PAT_ORLIT | {6'h00, 8'($urandom)};
      6: return PAT_XORLIT | {6'h00, 8'($urandom)};
      7: return PAT_DIRLD | {11'h000, 3'($urandom)}; // selectors 0..4 take the unknown path, 5..7 load
      default: return 14'h3f00 | {6'h00, 8'($urandom)};
    endcase
  endfunction
  task automatic predict(input logic [13:0] v);
    logic [7:0] src, res;
    logic       toDest, toAcc, dirHit;
    {ePc, eDis, eAw, eRw, eZw, eUnk, toDest, toAcc} = '0;
    eReady = 1'b1;
    res = 8'h00;
    dirHit = bankHigh && v[6:0] >= 7'h05 && v[6:0] <= 7'h07;
    src = dirHit ? mDir[v[1:0]+2'h3] : mMem[{bankHigh, v[6:0]}];
    if ((v & MASK_JUMP) == PAT_JUMP) begin
      {ePc, eReady, ePcv} = {2'b10, upperLatch[4:3], v[10:0]};
    end else if ((v & MASK_DIRLD) == PAT_DIRLD) begin
      if (v[2:0] >= DIR_SEL_MIN) mDir[v[2:0]-3'h5] = mAcc;
      else eUnk = 1'b1;
    end else begin
      case (v & MASK_OP6)
        PAT_INCSKIP: {res, toDest, eDis, eReady} = {src + 8'h01, 1'b1, src == 8'hff, src != 8'hff};
        PAT_INC:     {res, toDest, eZw} = {src + 8'h01, 2'b11};
        PAT_SWAP:    {res, toDest} = {src[3:0], src[7:4], 1'b1};
        PAT_XORREG:  {res, toDest, eZw} = {mAcc ^ src, 2'b11};
        PAT_ORLIT:   {res, toAcc, eZw} = {mAcc | v[7:0], 2'b11};
        PAT_XORLIT:  {res, toAcc, eZw} = {mAcc ^ v[7:0], 2'b11};
        default:     eUnk = 1'b1;
      endcase
    end
    eZv = (res == 8'h00);
    if (toAcc || (toDest && !v[7])) {eAw, eAccD, mAcc} = {1'b1, res, res};
    else if (toDest && dirHit) mDir[v[1:0]+2'h3] = res;
    else if (toDest) {eRw, eRegA, eRegD} = {1'b1, v[6:0], res};
    if (eRw) mMem[{bankHigh, v[6:0]}] = res;
  endtask
  task automatic do_reset();
    srst = 1'b1;
    instrValid = 1'b0;
    mAcc = 8'h00;
    mDir = '{8'hff, 8'hff, 8'hff};
    for (int i = 0; i < 256; i++) mMem[i] = 8'(i) ^ 8'hf0;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    check(24'(instrReady), 24'h1);
    check(dirBits, 24'hffffff);
    check(24'({pcLoad, discardFetch, accWrite, regWrite, zeroWrite, unknownOp}), 24'h0);
    check(24'(pcLoadValue), 24'h0);
    check(24'({accWrData, regWrAddr, regWrData, zeroValue}), 24'h0);
  endtask
  initial begin
    {mclk, srst, instrValid, instrWord, bankHigh, upperLatch} = {2'b01, 24'h0};
    {failures, samples_checked, cycles} = '0;
    seedDummy = $urandom(32'h7c89);
    do_reset();
    for (int n = 0; n < 500; n++) begin
      if (n == 250) do_reset();
      bankHigh = 1'($urandom);
      upperLatch = 8'($urandom);
      w = gen_word();
      predict(w);
      instrValid = 1'b1;
      instrWord = w;
      @(negedge mclk);
      check(24'(instrReady), 24'(eReady));
      check(24'(pcLoad), 24'(ePc));
      if (ePc) check(24'(pcLoadValue), 24'(ePcv));
      check(24'(discardFetch), 24'(eDis));
      check(24'(accWrite), 24'(eAw));
      if (eAw) check(24'(accWrData), 24'(eAccD));
      check(24'(regWrite), 24'(eRw));
      if (eRw) check(24'({regWrAddr, regWrData}), 24'({eRegA, eRegD}));
      check(24'(zeroWrite), 24'(eZw));
      if (eZw) check(24'(zeroValue), 24'(eZv));
      check(24'(unknownOp), 24'(eUnk));
      check(dirBits, {mDir[2], mDir[1], mDir[0]});
      // during the bubble a fresh word stays offered and must be refused
      if (!eReady) instrWord = PAT_ORLIT | {6'h00, 8'($urandom)};
      else instrValid = 1'b0;
      @(negedge mclk);
      check(24'({pcLoad, discardFetch, accWrite, regWrite, zeroWrite, unknownOp}), 24'h0);
      check(24'(instrReady), 24'h1);
    end
    test_done();
  end
endmodule
